// *** hw/oag_pkg.sv ***
/*
  Shared types and constants for the operand address generation block.
  Assumes a 16-bit data path, sixteen working registers and byte-addressed
  data memory in which a word step is two bytes.
*/
`default_nettype none

package oag_pkg;

  // ==========================================================================
  // Widths and fixed figures
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned REG_IDX_W   = 4;
  localparam int unsigned FILE_ADDR_W = 13;
  localparam int unsigned LIT_SHORT_W = 5;
  localparam int unsigned LIT_LONG_W  = 10;

  localparam logic [3:0]  DEFAULT_WORKING_REGISTER_IDX    = 4'h0;
  localparam logic [15:0] STEP_BYTE   = 16'h0001;
  localparam logic [15:0] STEP_WORD   = 16'h0002;

  // ==========================================================================
  // Instruction classes and addressing modes
  typedef enum logic [2:0] {
    CLS_FILE = 3'b000,
    CLS_MCU3 = 3'b001,
    CLS_MOVE = 3'b010,
    CLS_MULT = 3'b011,
    CLS_MACC = 3'b100
  } oag_class_type;

  typedef enum logic [2:0] {
    MODE_FILE_DIRECT = 3'b000,
    MODE_REG_DIRECT  = 3'b001,
    MODE_REG_IND     = 3'b010,
    MODE_POST_MOD    = 3'b011,
    MODE_PRE_MOD     = 3'b100,
    MODE_REG_INDEXED = 3'b101,
    MODE_LIT_OFFSET  = 3'b110,
    MODE_LITERAL     = 3'b111
  } oag_mode_type;

  // Legal mode masks, bit n set means mode code n is accepted
  localparam logic [7:0] MODES_FILE = 8'h01;
  localparam logic [7:0] MODES_MCU3 = 8'h9e;
  localparam logic [7:0] MODES_MOVE = 8'hff;
  localparam logic [7:0] MODES_MULT = 8'h01;
  localparam logic [7:0] MODES_MACC = 8'h2c;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic          valid;
    oag_class_type iclass;
    oag_mode_type  mode;
    logic [3:0]    ptr_idx;
    logic [3:0]    base_idx;
    logic [3:0]    dst_idx;
    logic [15:0]   file_addr;
    logic [9:0]    literal;
    logic          lit_wide;
    logic          mod_dec;
    logic          byte_op;
    logic          dst_to_default_working_register;
    logic          dst_to_mem;
    logic          dst_pair;
  } oag_req_type;

  typedef struct packed {
    logic        valid;
    logic        illegal;
    logic        mem_rd;
    logic [15:0] ea;
    logic        src_from_reg;
    logic [3:0]  src_reg_idx;
    logic        src_is_lit;
    logic [15:0] lit_val;
    logic        op1_from_reg;
    logic [3:0]  op1_reg_idx;
    logic        dst_is_mem;
    logic [15:0] dst_addr;
    logic        dst_is_reg;
    logic [3:0]  dst_reg_idx;
    logic        dst_pair;
  } oag_resp_type;

  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [15:0] data;
  } oag_ptr_upd_type;

endpackage : oag_pkg

`default_nettype wire

// *** hw/oag_ea_unit.sv ***
/*
  Effective address arithmetic for the pointer-based addressing modes.
  Purely combinational; the caller registers the results and supplies
  pointer and base values already forwarded.
*/
`default_nettype none

module oag_ea_unit
  import oag_pkg::*;
#(
  parameter int unsigned DW = 16
)
(
  // Request fields
  input  wire oag_mode_type mode,
  input  wire logic [9:0]   literal,
  input  wire logic         mod_dec,
  input  wire logic         byte_op,
  // Register values
  input  wire logic [DW-1:0] ptr_val,
  input  wire logic [DW-1:0] base_val,
  // Results
  output logic [DW-1:0]      ea,
  output logic [DW-1:0]      ptr_new,
  output logic               ptr_write
);

  logic [DW-1:0] step;
  logic [DW-1:0] modified;
  logic [DW-1:0] lit_sext;

  assign step     = byte_op ? DW'(STEP_BYTE) : DW'(STEP_WORD);
  assign modified = mod_dec ? ptr_val - step : ptr_val + step;
  assign lit_sext = DW'($signed(literal));

  always_comb
  begin
    ea        = ptr_val;
    ptr_new   = ptr_val;
    ptr_write = 1'b0;
    case (mode)
      MODE_REG_IND:
      begin
        ea = ptr_val;
      end
      MODE_POST_MOD:
      begin
        ea        = ptr_val;
        ptr_new   = modified;
        ptr_write = 1'b1;
      end
      MODE_PRE_MOD:
      begin
        ea        = modified;
        ptr_new   = modified;
        ptr_write = 1'b1;
      end
      MODE_REG_INDEXED:
      begin
        ea = ptr_val + base_val;
      end
      MODE_LIT_OFFSET:
      begin
        ea = ptr_val + lit_sext;
      end
      default:
      begin
        ea = ptr_val;
      end
    endcase
  end

endmodule : oag_ea_unit

`default_nettype wire

// *** hw/oag_operand_address.sv ***
/*
  Operand address generation: turns a decoded instruction into operand
  sources, an effective address, a destination and a pointer write-back.
  Assumes the register file answers ptr_val/base_val combinationally for
  req.ptr_idx/req.base_idx and writes ptr_upd at the next clock edge.
*/
`default_nettype none

// Function
// - Direct file instructions address the lowest 8192 bytes via 13-bit field.
// - Working register zero is the default working register for direct file forms.
// - Direct file result goes back to file or default register; multiply writes register(s).
// - Data transfer instruction reaches the whole data space directly.
// - Three-operand first source is always the base working register, direct.
// - Three-operand second source is a register, memory via register, or a 5/10-bit literal.
// - Three-operand result goes to a working register or data memory.
// - Three-operand forms support direct, indirect, post, pre modes and 5/10-bit literals.
// - Each instruction accepts only its own subset of addressing modes.
// - File direct mode uses the address in the instruction, no pointer.
// - Register direct accesses the register itself, no memory access.
// - Register indirect uses the pointer register as effective address.
// - Post-modified uses current pointer, then steps it by a constant.
// - Pre-modified steps the pointer first, then uses the new value.
// - Register indexed address is pointer plus base working register.
// - Literal offset address is pointer plus instruction literal.
// - Multiply-accumulate class uses its own addressing-mode set.

module oag_operand_address
  import oag_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Decoded instruction
  input  wire oag_req_type      req,
  // Register file read values
  input  wire logic [15:0]      ptr_val,
  input  wire logic [15:0]      base_val,
  // Operand and destination description
  output oag_resp_type          resp,
  // Pointer register write-back
  output oag_ptr_upd_type       ptr_upd
);

  // ==========================================================================
  // Internal state
  oag_resp_type    resp_reg;
  oag_resp_type    resp_next;
  oag_ptr_upd_type upd_reg;
  oag_ptr_upd_type upd_next;

  logic [15:0] ptr_eff;
  logic [15:0] base_eff;
  logic [7:0]  allowed;
  logic        mode_ok;
  logic [15:0] ea_calc;
  logic [15:0] ptr_calc;
  logic        ptr_write;
  logic [15:0] file_ea;

  assign resp    = resp_reg;
  assign ptr_upd = upd_reg;

  // ==========================================================================
  // Forwarding
  // The register file only takes the write-back at the edge that ends the
  // cycle in which it is shown, so a request in that cycle reads a stale
  // value; bypass it here rather than stall.
  always_comb
  begin
    ptr_eff  = ptr_val;
    base_eff = base_val;
    if (upd_reg.en && (upd_reg.idx == req.ptr_idx))
    begin
      ptr_eff = upd_reg.data;
    end
    if (upd_reg.en && (upd_reg.idx == req.base_idx))
    begin
      base_eff = upd_reg.data;
    end
  end

  // ==========================================================================
  // Mode legality per class
  always_comb
  begin
    case (req.iclass)
      CLS_FILE: allowed = MODES_FILE;
      CLS_MCU3: allowed = MODES_MCU3;
      CLS_MOVE: allowed = MODES_MOVE;
      CLS_MULT: allowed = MODES_MULT;
      CLS_MACC: allowed = MODES_MACC;
      default:  allowed = 8'h00;
    endcase
  end

  assign mode_ok = allowed[req.mode];

  // ==========================================================================
  // Address arithmetic
  oag_ea_unit #(
    .DW (16)
  ) u_ea (
    .mode      (req.mode),
    .literal   (req.literal),
    .mod_dec   (req.mod_dec),
    .byte_op   (req.byte_op),
    .ptr_val   (ptr_eff),
    .base_val  (base_eff),
    .ea        (ea_calc),
    .ptr_new   (ptr_calc),
    .ptr_write (ptr_write)
  );

  // Only the data transfer form sees the full space; others are clipped
  // to the low direct region.
  assign file_ea = (req.iclass == CLS_MOVE) ? req.file_addr
                 : {3'h0, req.file_addr[FILE_ADDR_W-1:0]};

  // ==========================================================================
  // Operand and destination decode
  always_comb
  begin
    resp_next       = '0;
    upd_next        = '0;
    resp_next.valid = req.valid;
    if (req.valid && !mode_ok)
    begin
      // Refused modes produce no access and no pointer write
      resp_next.illegal = 1'b1;
    end
    else if (req.valid)
    begin
      case (req.mode)
        MODE_FILE_DIRECT:
        begin
          resp_next.mem_rd = 1'b1;
          resp_next.ea     = file_ea;
        end
        MODE_REG_DIRECT:
        begin
          resp_next.src_from_reg = 1'b1;
          resp_next.src_reg_idx  = req.ptr_idx;
        end
        MODE_LITERAL:
        begin
          resp_next.src_is_lit = 1'b1;
          if (req.lit_wide)
          begin
            resp_next.lit_val = {6'h00, req.literal};
          end
          else
          begin
            resp_next.lit_val = {11'h000, req.literal[LIT_SHORT_W-1:0]};
          end
        end
        default:
        begin
          // All pointer-based modes fetch from memory
          resp_next.mem_rd = 1'b1;
          resp_next.ea     = ea_calc;
          upd_next.en      = ptr_write;
          upd_next.idx     = req.ptr_idx;
          upd_next.data    = ptr_calc;
        end
      endcase

      if (req.iclass == CLS_MCU3)
      begin
        resp_next.op1_from_reg = 1'b1;
        resp_next.op1_reg_idx  = req.base_idx;
      end

      if (req.iclass == CLS_MULT)
      begin
        // Multiply always lands in a register or an adjacent pair
        resp_next.dst_is_reg  = 1'b1;
        resp_next.dst_reg_idx = req.dst_idx;
        resp_next.dst_pair    = req.dst_pair;
      end
      else if (req.mode == MODE_FILE_DIRECT)
      begin
        if (req.dst_to_default_working_register)
        begin
          resp_next.dst_is_reg  = 1'b1;
          resp_next.dst_reg_idx = DEFAULT_WORKING_REGISTER_IDX;
        end
        else
        begin
          resp_next.dst_is_mem = 1'b1;
          resp_next.dst_addr   = file_ea;
        end
      end
      else if (req.dst_to_mem)
      begin
        resp_next.dst_is_mem = 1'b1;
        resp_next.dst_addr   = ea_calc;
      end
      else
      begin
        resp_next.dst_is_reg  = 1'b1;
        resp_next.dst_reg_idx = req.dst_idx;
      end
    end
  end

  // ==========================================================================
  // Output stage
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      resp_reg <= '0;
    end
    else
    begin
      resp_reg <= resp_next;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      upd_reg <= '0;
    end
    else
    begin
      upd_reg <= upd_next;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_legal(oag_class_type c, oag_mode_type m);
    req.valid && mode_ok && (req.iclass == c) && (req.mode == m);
  endsequence

  sequence s_ptr_mode(oag_mode_type m);
    req.valid && mode_ok && (req.iclass != CLS_MULT) && (req.mode == m);
  endsequence

  a_file_low_region: assert property (
    s_legal(CLS_FILE, MODE_FILE_DIRECT) |=>
      resp.mem_rd && (resp.ea == {3'h0, $past(req.file_addr[12:0])}) && !ptr_upd.en)
    else $error("file direct address not confined to low region");

  a_default_working_register_default: assert property (
    s_legal(CLS_FILE, MODE_FILE_DIRECT) ##0 req.dst_to_default_working_register |=>
      resp.dst_is_reg && !resp.dst_is_mem && (resp.dst_reg_idx == 4'h0))
    else $error("default working register not selected");

  a_file_dest_same: assert property (
    s_legal(CLS_FILE, MODE_FILE_DIRECT) ##0 !req.dst_to_default_working_register |=>
      resp.dst_is_mem && (resp.dst_addr == resp.ea))
    else $error("file result not written back to same file register");

  a_mul_dest_reg: assert property (
    s_legal(CLS_MULT, MODE_FILE_DIRECT) |=>
      resp.dst_is_reg && (resp.dst_reg_idx == $past(req.dst_idx)) && (resp.dst_pair == $past(req.dst_pair)))
    else $error("multiply destination wrong");

  a_move_full_space: assert property (
    s_legal(CLS_MOVE, MODE_FILE_DIRECT) |=> resp.ea == $past(req.file_addr))
    else $error("data transfer address clipped");

  a_base_direct: assert property (
    req.valid && mode_ok && (req.iclass == CLS_MCU3) |=>
      resp.op1_from_reg && (resp.op1_reg_idx == $past(req.base_idx)))
    else $error("first operand not from base register");

  a_lit_short: assert property (
    s_legal(CLS_MCU3, MODE_LITERAL) ##0 !req.lit_wide |=>
      resp.src_is_lit && !resp.mem_rd && (resp.lit_val == {11'h000, $past(req.literal[4:0])}))
    else $error("short literal not formed from five bits");

  a_mode_gate: assert property (
    req.valid && !mode_ok |=> resp.illegal && !resp.mem_rd && !ptr_upd.en && !resp.dst_is_mem)
    else $error("refused mode still acted");

  a_reg_direct_nomem: assert property (
    s_ptr_mode(MODE_REG_DIRECT) |=>
      !resp.mem_rd && resp.src_from_reg && (resp.src_reg_idx == $past(req.ptr_idx)))
    else $error("register direct touched memory");

  a_post_modify: assert property (
    s_ptr_mode(MODE_POST_MOD) |=>
      (resp.ea == $past(ptr_eff)) && ptr_upd.en && (ptr_upd.idx == $past(req.ptr_idx))
      && (ptr_upd.data != resp.ea))
    else $error("post-modify address or update wrong");

  a_pre_modify: assert property (
    s_ptr_mode(MODE_PRE_MOD) |=> ptr_upd.en && (resp.ea == ptr_upd.data) && (resp.ea != $past(ptr_eff)))
    else $error("pre-modify did not use updated pointer");

  a_indexed_sum: assert property (
    s_ptr_mode(MODE_REG_INDEXED) |=> (resp.ea == 16'($past(ptr_eff) + $past(base_eff))) && !ptr_upd.en)
    else $error("indexed address not pointer plus base");

  a_mac_no_file: assert property (
    req.valid && (req.iclass == CLS_MACC) && (req.mode == MODE_FILE_DIRECT) |=> resp.illegal)
    else $error("accumulate class accepted file direct mode");

  a_ptr_forward: assert property (
    (ptr_upd.en and s_ptr_mode(MODE_REG_IND)) ##0 (req.ptr_idx == ptr_upd.idx) |=>
      resp.ea == $past(ptr_upd.data))
    else $error("updated pointer not seen by next instruction");

  a_reg_indirect: assert property (
    s_ptr_mode(MODE_REG_IND) |=> resp.mem_rd && (resp.ea == $past(ptr_eff)) && !ptr_upd.en)
    else $error("register indirect address not the pointer");

  a_post_step: assert property (
    s_ptr_mode(MODE_POST_MOD) ##0 !req.byte_op ##0 !req.mod_dec |=>
      ptr_upd.data == 16'($past(ptr_eff) + STEP_WORD))
    else $error("post-modify step not one word upward");

  a_lit_offset_sum: assert property (
    s_ptr_mode(MODE_LIT_OFFSET) |=>
      (resp.ea == 16'($past(ptr_eff) + 16'($signed($past(req.literal))))) && !ptr_upd.en)
    else $error("literal offset address not pointer plus literal");

  a_lit_wide: assert property (
    s_ptr_mode(MODE_LITERAL) ##0 req.lit_wide |=>
      resp.src_is_lit && !resp.mem_rd && (resp.lit_val == {6'h00, $past(req.literal)}))
    else $error("wide literal not formed from ten bits");

  a_dest_to_mem: assert property (
    s_legal(CLS_MCU3, MODE_REG_IND) ##0 req.dst_to_mem |=>
      resp.dst_is_mem && !resp.dst_is_reg && (resp.dst_addr == resp.ea))
    else $error("three-operand result not sent to memory");

  a_dest_to_reg: assert property (
    s_legal(CLS_MCU3, MODE_POST_MOD) ##0 !req.dst_to_mem |=>
      resp.dst_is_reg && !resp.dst_is_mem && (resp.dst_reg_idx == $past(req.dst_idx)))
    else $error("three-operand result not sent to working register");

  a_file_no_pointer: assert property (
    s_ptr_mode(MODE_FILE_DIRECT) |=> resp.mem_rd && !resp.src_from_reg && !ptr_upd.en)
    else $error("file direct mode used a pointer");

endmodule : oag_operand_address

`default_nettype wire

// *** bench/oag_regfile_model.sv ***
/*
  Working register file model that faces the operand address block.
  Assumes one pointer write at a time on ptr_upd and combinational reads.
*/
`default_nettype none

module oag_regfile_model
  import oag_pkg::*;
(
  // Clock
  input  wire logic            clk_sys,
  // Read ports
  input  wire logic [3:0]      ptr_idx,
  input  wire logic [3:0]      base_idx,
  output logic [15:0]          ptr_val,
  output logic [15:0]          base_val,
  // Pointer write-back
  input  wire oag_ptr_upd_type ptr_upd
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] regs [16];

  // ==========================================================================
  // Storage, seeded with distinct values so mixed-up indices show
  initial
  begin
    for (int i = 0; i < 16; i++)
      regs[i] = 16'h1000 + 16'(i * 256);
  end

  assign ptr_val  = regs[ptr_idx];
  assign base_val = regs[base_idx];

  // Stale until this edge; the block must forward to the request beside it
  always @(posedge clk_sys)
  begin
    if (ptr_upd.en === 1'b1)
      regs[ptr_upd.idx] <= ptr_upd.data;
  end

endmodule : oag_regfile_model

`default_nettype wire

// *** bench/tb_top.sv ***
/*
  Self-checking bench for the operand address block with a reference model.
  Assumes the register file model seeds register i with 0x1000 + i*0x100.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import oag_pkg::*;

  logic            clk_sys;
  logic            resetn;
  oag_req_type     req;
  logic [15:0]     ptr_val;
  logic [15:0]     base_val;
  oag_resp_type    resp;
  oag_ptr_upd_type ptr_upd;
  int              miscompares;
  int              checks_done;
  int              cycles;
  logic [31:0]     seed;
  logic [15:0]     mreg [16];
  oag_resp_type    pnd_e, pnd_c, stg_e, stg_c;
  oag_ptr_upd_type pnd_u, stg_u;
  oag_req_type     r;

  oag_operand_address u_dut (.clk_sys(clk_sys), .resetn(resetn), .req(req), .ptr_val(ptr_val),
                             .base_val(base_val), .resp(resp), .ptr_upd(ptr_upd));
  oag_regfile_model u_rf (.clk_sys(clk_sys), .ptr_idx(req.ptr_idx), .base_idx(req.base_idx),
                          .ptr_val(ptr_val), .base_val(base_val), .ptr_upd(ptr_upd));

  // ==========================================================================
  // Random source
  function automatic logic [31:0] nxt();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : nxt

  task automatic rnd_req(output oag_req_type q);
    q = '0;
    q.valid = 1'b1;
    q.iclass = oag_class_type'(3'(nxt() % 5));
    q.mode = oag_mode_type'(3'(nxt()));
    {q.ptr_idx, q.base_idx, q.dst_idx} = 12'(nxt());
    q.file_addr = 16'(nxt());
    q.literal = 10'(nxt());
    {q.lit_wide, q.mod_dec, q.byte_op, q.dst_to_default_working_register, q.dst_to_mem, q.dst_pair} = 6'(nxt() >> 7);
  endtask : rnd_req

  // ==========================================================================
  // Reference model; care mask selects the fields the rules pin down
  task automatic predict(input oag_req_type q, output oag_resp_type e, output oag_resp_type c,
                         output oag_ptr_upd_type u);
    logic [7:0]  m;
    logic [15:0] p;
    logic [15:0] np;
    logic [15:0] st;
    m = (q.iclass == CLS_FILE) ? MODES_FILE : (q.iclass == CLS_MCU3) ? MODES_MCU3 :
        (q.iclass == CLS_MOVE) ? MODES_MOVE : (q.iclass == CLS_MULT) ? MODES_MULT : MODES_MACC;
    p = mreg[q.ptr_idx];
    st = q.byte_op ? STEP_BYTE : STEP_WORD;
    np = q.mod_dec ? p - st : p + st;
    e = '0;
    c = '1;
    u = '0;
    e.valid = 1'b1;
    if (!m[q.mode])
    begin
      e.illegal = 1'b1;
      return;
    end
    c = '0;
    c.valid = 1'b1;
    c.illegal = 1'b1;
    c.mem_rd = 1'b1;
    e.mem_rd = (q.mode inside {[0:0], [2:6]});
    c.ea = (q.mode inside {[0:0], [2:6]}) ? '1 : '0;
    case (q.mode)
      MODE_FILE_DIRECT:
      begin
        e.ea = (q.iclass == CLS_MOVE) ? q.file_addr : {3'h0, q.file_addr[12:0]};
      end
      MODE_REG_DIRECT:
      begin
        e.src_from_reg = 1'b1;
        e.src_reg_idx = q.ptr_idx;
        c.src_from_reg = 1'b1;
        c.src_reg_idx = '1;
      end
      MODE_REG_IND: e.ea = p;
      MODE_POST_MOD:
      begin
        e.ea = p;
        u = {1'b1, q.ptr_idx, np};
      end
      MODE_PRE_MOD:
      begin
        e.ea = np;
        u = {1'b1, q.ptr_idx, np};
      end
      MODE_REG_INDEXED: e.ea = p + mreg[q.base_idx];
      MODE_LIT_OFFSET: e.ea = p + {{6{q.literal[9]}}, q.literal};
      default:
      begin
        e.src_is_lit = 1'b1;
        e.lit_val = q.lit_wide ? {6'h00, q.literal} : {11'h000, q.literal[4:0]};
        c.src_is_lit = 1'b1;
        c.lit_val = '1;
      end
    endcase
    if (q.iclass == CLS_MCU3)
    begin
      e.op1_from_reg = 1'b1;
      e.op1_reg_idx = q.base_idx;
      c.op1_from_reg = 1'b1;
      c.op1_reg_idx = '1;
    end
    if (q.iclass == CLS_MULT)
    begin
      e.dst_is_reg = 1'b1;
      e.dst_reg_idx = q.dst_idx;
      e.dst_pair = q.dst_pair;
      c.dst_pair = 1'b1;
    end
    else if (q.mode == MODE_FILE_DIRECT)
    begin
      e.dst_is_reg = q.dst_to_default_working_register;
      e.dst_is_mem = !q.dst_to_default_working_register;
      e.dst_addr = q.dst_to_default_working_register ? 16'h0000 : e.ea;
      e.dst_reg_idx = DEFAULT_WORKING_REGISTER_IDX;
    end
    else if (q.mode inside {[2:6]})
    begin
      e.dst_is_mem = q.dst_to_mem;
      e.dst_is_reg = !q.dst_to_mem;
      e.dst_addr = q.dst_to_mem ? e.ea : 16'h0000;
      e.dst_reg_idx = q.dst_to_mem ? 4'h0 : q.dst_idx;
    end
    if (q.iclass != CLS_MACC && (q.mode == MODE_FILE_DIRECT || q.mode inside {[2:6]}))
    begin
      c.dst_is_reg = 1'b1;
      c.dst_is_mem = 1'b1;
      c.dst_addr = e.dst_is_mem ? '1 : '0;
      c.dst_reg_idx = e.dst_is_reg ? '1 : '0;
    end
    if (u.en)
      mreg[u.idx] = u.data;
  endtask : predict

  // ==========================================================================
  // Drivers and comparisons
  task automatic issue(input oag_req_type q);
    @(posedge clk_sys);
    req <= q;
    predict(q, pnd_e, pnd_c, pnd_u);
  endtask : issue

  task automatic idle();
    @(posedge clk_sys);
    req <= '0;
  endtask : idle

  task automatic check_resp(input oag_resp_type e, input oag_resp_type c);
    checks_done++;
    if (((resp ^ e) & c) !== '0)
    begin
      miscompares++;
      $display("Error at %0t: operand response %h, expected %h", $time, resp, e);
    end
  endtask : check_resp

  task automatic check_upd(input oag_ptr_upd_type e);
    checks_done++;
    if (ptr_upd.en !== e.en || (e.en && {ptr_upd.idx, ptr_upd.data} !== {e.idx, e.data}))
    begin
      miscompares++;
      $display("Error at %0t: pointer update %h, expected %h", $time, ptr_upd, e);
    end
  endtask : check_upd

  task automatic tally_and_finish();
    $display("Totals: %0d comparisons, %0d mismatches", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Answers stand one cycle after the taking edge, so check mid-cycle
  always @(negedge clk_sys)
  begin
    check_resp(stg_e, stg_c);
    check_upd(stg_u);
    stg_e = pnd_e;
    stg_c = pnd_c;
    stg_u = pnd_u;
    pnd_e = '0;
    pnd_c = '1;
    pnd_u = '0;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      $display("Error at %0t: run did not complete in time", $time);
      tally_and_finish();
    end
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    resetn = 1'b0;
    req = '0;
    seed = 32'h2343;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    pnd_e = '0;
    pnd_c = '1;
    pnd_u = '0;
    stg_e = '0;
    stg_c = '1;
    stg_u = '0;
    for (int i = 0; i < 16; i++)
      mreg[i] = 16'h1000 + 16'(i * 256);
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    idle();
    $display("Test reset done");
    // Back-to-back pointer reuse exercises forwarding of fresh updates
    r = '0;
    r.valid = 1'b1;
    r.iclass = CLS_MOVE;
    r.ptr_idx = 4'h2;
    r.base_idx = 4'h2;
    r.literal = 10'h3ff;
    for (int m = 3; m >= 2; m--)
    begin
      r.mode = oag_mode_type'(3'(m));
      issue(r);
    end
    r.mode = MODE_PRE_MOD;
    r.mod_dec = 1'b1;
    r.byte_op = 1'b1;
    issue(r);
    r.ptr_idx = 4'h3;
    r.mode = MODE_REG_INDEXED;
    issue(r);
    r.mode = MODE_LIT_OFFSET;
    issue(r);
    idle();
    $display("Test pointer walk done");
    // Every class against every mode
    for (int k = 0; k < 5; k++)
      for (int m = 0; m < 8; m++)
      begin
        rnd_req(r);
        r.iclass = oag_class_type'(3'(k));
        r.mode = oag_mode_type'(3'(m));
        issue(r);
      end
    $display("Test mode sweep done");
    for (int n = 0; n < 300; n++)
    begin
      rnd_req(r);
      if (n % 7 == 6)
        idle();
      else
        issue(r);
    end
    repeat (3) idle();
    $display("Test random traffic done");
    tally_and_finish();
  end

endmodule : tb_top

`default_nettype wire
